//--- core_defines.svh
// Purpose: Offsets, field positions and reset values for the instruction subset block.
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one aligned word per register.
// Notes:   Definitions only; included by bare name.
`ifndef CORE_DEFINES_SVH
`define CORE_DEFINES_SVH

// Register byte offsets within the block.
`define ADDR_CMD        8'h00
`define ADDR_ACC        8'h04
`define ADDR_STATUS     8'h08
`define ADDR_PC         8'h0c
`define ADDR_STACK      8'h10
`define ADDR_FILE_PTR   8'h14
`define ADDR_FILE_DATA  8'h18
`define ADDR_WATCHDOG   8'h1c
`define ADDR_WAKE       8'h20

// Command word fields.
`define CMD_OP_LSB      0
`define CMD_OP_MSB      2
`define CMD_FADDR_LSB   8
`define CMD_FADDR_MSB   14
`define CMD_DEST_BIT    15
`define CMD_LIT_LSB     16
`define CMD_LIT_MSB     23

// Status word fields.
`define ST_CARRY_BIT    0
`define ST_HALF_BIT     1
`define ST_ZERO_BIT     2
`define ST_POWER_BIT    3
`define ST_EXPIRY_BIT   4
`define ST_ASLEEP_BIT   5
`define ST_BUSY_BIT     6

// Watchdog word fields.
`define WD_COUNT_LSB    0
`define WD_PRESC_LSB    8

// Reset values.
`define RST_ACC         8'h00
`define RST_PC          13'h0000
`define RST_POWER_FLAG  1'b1
`define RST_EXPIRY_FLAG 1'b1

`endif

//--- core_pkg.sv
// Purpose: Types shared by the instruction subset block and its arithmetic unit.
// Assumes: Opcode values follow declaration order, starting at zero.
// Notes:   Codes above the last opcode are illegal and are ignored.
package core_pkg;

   // Instruction opcodes carried in the command word.
   typedef enum logic [2:0] {
      OP_RETURN,
      OP_ROTATE_LEFT,
      OP_ROTATE_RIGHT,
      OP_SLEEP,
      OP_LIT_MINUS_ACC
   } op_type;

   // Execution sequencer states.
   typedef enum logic {
      ST_IDLE,
      ST_RETURN_SECOND
   } seq_type;

endpackage

//--- core_alu.sv
// Purpose: Combinational rotate and subtract unit of the instruction subset block.
// Assumes: Operands are stable for the cycle in which the result is used.
// Notes:   Flags are produced for every opcode; the caller picks which to keep.
`timescale 1ns/100ps

module core_alu
(
   // Operation select.
   input  wire logic [2:0] op,
   // Operands.
   input  wire logic [7:0] file_value,
   input  wire logic [7:0] acc_value,
   input  wire logic [7:0] literal,
   input  wire logic       carry_in,
   // Results.
   output logic      [7:0] result,
   output logic            carry_out,
   output logic            half_carry_out,
   output logic            zero_out
);

   ////////////////////////////////////////////////////////////////////////////
   logic [8:0] diff;
   logic [4:0] low_diff;

   // Borrow appears in the top bit of the widened differences: the ninth bit, or the fifth for the low nibble.
   assign diff     = {1'b0, literal} - {1'b0, acc_value};
   assign low_diff = {1'b0, literal[3:0]} - {1'b0, acc_value[3:0]};

   // Result and flags per opcode.
   always_comb
   begin
      result         = 8'h00;
      carry_out      = carry_in;
      half_carry_out = 1'b0;
      if (op == 3'(core_pkg::OP_ROTATE_LEFT))
      begin
         result    = {file_value[6:0], carry_in};
         carry_out = file_value[7];
      end
      else if (op == 3'(core_pkg::OP_ROTATE_RIGHT))
      begin
         result    = {carry_in, file_value[7:1]};
         carry_out = file_value[0];
      end
      else if (op == 3'(core_pkg::OP_LIT_MINUS_ACC))
      begin
         result         = diff[7:0];
         carry_out      = ~diff[8];
         half_carry_out = ~low_diff[4];
      end
      zero_out = (result == 8'h00);
   end

endmodule

//--- core_return_rotate_sleep_sub.sv
// Purpose: Executes return, rotate through carry, sleep and literal-minus-accumulator.
// Assumes: Single core clock, synchronous active-low reset, AHB-Lite single word transfers.
// Notes:   Reads take one wait state; the bus is held off while an instruction is busy.
`timescale 1ns/100ps
`include "core_defines.svh"

module core_return_rotate_sleep_sub
#(
   parameter int STACK_DEPTH = 8,
   parameter int FILE_WORDS  = 128,
   parameter int PC_WIDTH    = 13
)
(
   // Clock and reset.
   input  wire logic        CLK,
   input  wire logic        RSTN,
   // AHB-Lite slave port.
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Core state shown to the rest of the chip.
   output logic             ASLEEP,
   output logic [PC_WIDTH-1:0] PROGRAM_COUNTER
);

   localparam int SP_WIDTH = $clog2(STACK_DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // State declarations.
   logic [7:0]          acc_q;
   logic                carry_q;
   logic                half_carry_q;
   logic                zero_q;
   logic                power_down_flag_q;
   logic                watchdog_expiry_flag_q;
   logic                asleep_q;
   logic [PC_WIDTH-1:0] pc_q;
   logic [PC_WIDTH-1:0] stack_q [STACK_DEPTH];
   logic [SP_WIDTH-1:0] sp_q;
   logic [SP_WIDTH:0]   depth_q;
   logic [7:0]          file_q [FILE_WORDS];
   logic [6:0]          file_ptr_q;
   logic [7:0]          watchdog_counter_q;
   logic [7:0]          prescaler_q;
   core_pkg::seq_type   state_q;

   // Bus bookkeeping.
   logic                wr_pend_q;
   logic                rd_pend_q;
   logic [7:0]          addr_q;
   logic [31:0]         rdata_q;

   // Latched instruction operands.
   logic [2:0]          op_q;
   logic [6:0]          faddr_q;
   logic                dest_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   logic        addr_phase;
   logic        wr_fire;
   logic        busy;
   logic [2:0]  cmd_op;
   logic [6:0]  cmd_faddr;
   logic        cmd_dest;
   logic [7:0]  cmd_lit;
   logic        cmd_legal;
   logic        exec;
   logic [SP_WIDTH-1:0] sp_pop;

   // A transfer is taken when selected, non-idle and the bus is ready.
   assign addr_phase = HSEL & HTRANS[1] & HREADY;
   assign busy       = (state_q != core_pkg::ST_IDLE);

   // Write data phase completes on this edge; reads wait for the sequencer.
   assign wr_fire    = wr_pend_q;

   // Command word fields.
   assign cmd_op    = HWDATA[`CMD_OP_MSB:`CMD_OP_LSB];
   assign cmd_faddr = HWDATA[`CMD_FADDR_MSB:`CMD_FADDR_LSB];
   assign cmd_dest  = HWDATA[`CMD_DEST_BIT];
   assign cmd_lit   = HWDATA[`CMD_LIT_MSB:`CMD_LIT_LSB];
   assign cmd_legal = (cmd_op <= 3'(core_pkg::OP_LIT_MINUS_ACC));

   // Instructions are refused while halted.
   assign exec   = wr_fire & (addr_q == `ADDR_CMD) & cmd_legal & ~asleep_q;
   assign sp_pop = sp_q - SP_WIDTH'(1);

   // Ready drops during a read wait state and while an instruction is busy.
   assign HREADYOUT = ~rd_pend_q & ~busy;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_q;
   assign ASLEEP    = asleep_q;
   assign PROGRAM_COUNTER = pc_q;

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic unit.
   logic [7:0] alu_result;
   logic       alu_carry;
   logic       alu_half;
   logic       alu_zero;
   logic [7:0] file_operand;

   assign file_operand = file_q[cmd_faddr];

   core_alu u_alu
   (
      .op             (cmd_op),
      .file_value     (file_operand),
      .acc_value      (acc_q),
      .literal        (cmd_lit),
      .carry_in       (carry_q),
      .result         (alu_result),
      .carry_out      (alu_carry),
      .half_carry_out (alu_half),
      .zero_out       (alu_zero)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address phase capture.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end
      else if (HREADYOUT)
      begin
         wr_pend_q <= addr_phase & HWRITE;
         if (addr_phase)
         begin
            addr_q <= HADDR[7:0];
         end
      end
   end

   // Read wait state and registered read data.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         rd_pend_q <= 1'b0;
         rdata_q   <= 32'h0000_0000;
      end
      else if (rd_pend_q)
      begin
         if (!busy)
         begin
            rd_pend_q <= 1'b0;
            unique case (addr_q)
               `ADDR_ACC:       rdata_q <= {24'h000000, acc_q};
               `ADDR_STATUS:    rdata_q <= {25'h0000000, busy, asleep_q,
                                            watchdog_expiry_flag_q, power_down_flag_q,
                                            zero_q, half_carry_q, carry_q};
               `ADDR_PC:        rdata_q <= 32'(pc_q);
               `ADDR_STACK:     rdata_q <= 32'(depth_q);
               `ADDR_FILE_PTR:  rdata_q <= {25'h0000000, file_ptr_q};
               `ADDR_FILE_DATA: rdata_q <= {24'h000000, file_q[file_ptr_q]};
               `ADDR_WATCHDOG:  rdata_q <= {16'h0000, prescaler_q, watchdog_counter_q};
               default:         rdata_q <= 32'h0000_0000;
            endcase
         end
      end
      else if (HREADYOUT && addr_phase && !HWRITE)
      begin
         rd_pend_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: return holds for a second cycle before the pop lands.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         state_q <= core_pkg::ST_IDLE;
         op_q    <= 3'h0;
         faddr_q <= 7'h00;
         dest_q  <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            core_pkg::ST_IDLE:
            begin
               if (exec && cmd_op == 3'(core_pkg::OP_RETURN))
               begin
                  state_q <= core_pkg::ST_RETURN_SECOND;
               end
               if (exec)
               begin
                  op_q    <= cmd_op;
                  faddr_q <= cmd_faddr;
                  dest_q  <= cmd_dest;
               end
            end
            core_pkg::ST_RETURN_SECOND:
            begin
               state_q <= core_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter: loaded by software or by the stack pop.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         pc_q <= `RST_PC;
      end
      else if (state_q == core_pkg::ST_RETURN_SECOND)
      begin
         pc_q <= stack_q[sp_pop];
      end
      else if (wr_fire && addr_q == `ADDR_PC)
      begin
         pc_q <= HWDATA[PC_WIDTH-1:0];
      end
   end

   // Call stack: software pushes, return pops; a circular buffer that wraps.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         sp_q    <= '0;
         depth_q <= '0;
      end
      else if (state_q == core_pkg::ST_RETURN_SECOND)
      begin
         sp_q <= sp_pop;
         if (depth_q != '0)
         begin
            depth_q <= depth_q - (SP_WIDTH+1)'(1);
         end
      end
      else if (wr_fire && addr_q == `ADDR_STACK)
      begin
         sp_q <= sp_q + SP_WIDTH'(1);
         if (depth_q != (SP_WIDTH+1)'(STACK_DEPTH))
         begin
            depth_q <= depth_q + (SP_WIDTH+1)'(1);
         end
      end
   end

   // Stack entries, one per level.
   genvar s;
   generate
      for (s = 0; s < STACK_DEPTH; s++)
      begin : g_stack
         always_ff @(posedge CLK)
         begin
            if (!RSTN)
            begin
               stack_q[s] <= '0;
            end
            else if (wr_fire && addr_q == `ADDR_STACK && !busy && sp_q == SP_WIDTH'(s))
            begin
               stack_q[s] <= HWDATA[PC_WIDTH-1:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         acc_q <= `RST_ACC;
      end
      else if (exec && cmd_op == 3'(core_pkg::OP_LIT_MINUS_ACC))
      begin
         acc_q <= alu_result;
      end
      else if (exec && (cmd_op == 3'(core_pkg::OP_ROTATE_LEFT) ||
                        cmd_op == 3'(core_pkg::OP_ROTATE_RIGHT)) && !cmd_dest)
      begin
         acc_q <= alu_result;
      end
      else if (wr_fire && addr_q == `ADDR_ACC)
      begin
         acc_q <= HWDATA[7:0];
      end
   end

   // Arithmetic flags: rotates touch carry only, subtract touches all three.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         carry_q      <= 1'b0;
         half_carry_q <= 1'b0;
         zero_q       <= 1'b0;
      end
      else if (exec && cmd_op == 3'(core_pkg::OP_LIT_MINUS_ACC))
      begin
         carry_q      <= alu_carry;
         half_carry_q <= alu_half;
         zero_q       <= alu_zero;
      end
      else if (exec && (cmd_op == 3'(core_pkg::OP_ROTATE_LEFT) ||
                        cmd_op == 3'(core_pkg::OP_ROTATE_RIGHT)))
      begin
         carry_q <= alu_carry;
      end
      else if (wr_fire && addr_q == `ADDR_STATUS)
      begin
         carry_q      <= HWDATA[`ST_CARRY_BIT];
         half_carry_q <= HWDATA[`ST_HALF_BIT];
         zero_q       <= HWDATA[`ST_ZERO_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // File register pointer for the software window.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         file_ptr_q <= 7'h00;
      end
      else if (wr_fire && addr_q == `ADDR_FILE_PTR)
      begin
         file_ptr_q <= HWDATA[6:0];
      end
   end

   // File registers, one per entry; rotate write-back only when destination is set.
   genvar f;
   generate
      for (f = 0; f < FILE_WORDS; f++)
      begin : g_file
         always_ff @(posedge CLK)
         begin
            if (!RSTN)
            begin
               file_q[f] <= 8'h00;
            end
            else if (exec && cmd_dest && cmd_faddr == 7'(f) &&
                     (cmd_op == 3'(core_pkg::OP_ROTATE_LEFT) ||
                      cmd_op == 3'(core_pkg::OP_ROTATE_RIGHT)))
            begin
               file_q[f] <= alu_result;
            end
            else if (wr_fire && addr_q == `ADDR_FILE_DATA && file_ptr_q == 7'(f))
            begin
               file_q[f] <= HWDATA[7:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog counter and prescaler; frozen while halted, gated by the halt flag.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         watchdog_counter_q <= 8'h00;
         prescaler_q        <= 8'h00;
      end
      else if (exec && cmd_op == 3'(core_pkg::OP_SLEEP))
      begin
         watchdog_counter_q <= 8'h00;
         prescaler_q        <= 8'h00;
      end
      else if (!asleep_q)
      begin
         prescaler_q <= prescaler_q + 8'h01;
         if (prescaler_q == 8'hff)
         begin
            watchdog_counter_q <= watchdog_counter_q + 8'h01;
         end
      end
   end

   // Power-down and expiry flags, both active low.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         power_down_flag_q      <= `RST_POWER_FLAG;
         watchdog_expiry_flag_q <= `RST_EXPIRY_FLAG;
      end
      else if (exec && cmd_op == 3'(core_pkg::OP_SLEEP))
      begin
         power_down_flag_q      <= 1'b0;
         watchdog_expiry_flag_q <= 1'b1;
      end
   end

   // Halt state: entered by sleep, left only by a write to the wake register.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         asleep_q <= 1'b0;
      end
      else if (exec && cmd_op == 3'(core_pkg::OP_SLEEP))
      begin
         asleep_q <= 1'b1;
      end
      else if (wr_fire && addr_q == `ADDR_WAKE)
      begin
         asleep_q <= 1'b0;
      end
   end

endmodule

//--- core_chk.sv
// Purpose: Bus timing and instruction effect checks for the instruction subset block.
// Assumes: Sees only the top module ports; the master runs one transfer at a time.
// Notes:   Bound into every instance of the block at the foot of this file.
`timescale 1ns/100ps

module core_chk
#(
   parameter int PC_WIDTH = 13
)
(
   // Clock and reset.
   input wire logic                CLK,
   input wire logic                RSTN,
   // AHB-Lite slave port.
   input wire logic                HSEL,
   input wire logic [31:0]         HADDR,
   input wire logic [1:0]          HTRANS,
   input wire logic                HWRITE,
   input wire logic [2:0]          HSIZE,
   input wire logic [31:0]         HWDATA,
   input wire logic                HREADY,
   input wire logic [31:0]         HRDATA,
   input wire logic                HREADYOUT,
   input wire logic                HRESP,
   // Core state.
   input wire logic                ASLEEP,
   input wire logic [PC_WIDTH-1:0] PROGRAM_COUNTER
);
   logic       wr_q;
   logic       rd_q;
   logic [7:0] addr_q;
   logic       slept_q;
   logic       take;
   logic       exec;
   logic       rdone;
   logic [2:0] op;

   // Decode of accepted transfers and of instruction writes.
   assign take  = HSEL && HTRANS[1] && HREADY && HREADYOUT;
   assign exec  = wr_q && (addr_q == 8'h00) && HREADYOUT;
   assign rdone = rd_q && HREADYOUT;
   assign op    = HWDATA[2:0];

   // Address phase memory; held while the slave inserts wait states.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end
      else if (HREADYOUT)
      begin
         wr_q   <= take && HWRITE;
         rd_q   <= take && !HWRITE;
         addr_q <= HADDR[7:0];
      end
   end

   // Remembers that a sleep has run since reset.
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         slept_q <= 1'b0;
      else if (exec && (op == 3'd3) && !ASLEEP)
         slept_q <= 1'b1;
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_resp_okay: assert property (HRESP == 1'b0)
      else $error("response is not OKAY");
   a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT)
      else $error("read answered without its wait state");
   a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
      else $error("write data phase stalled");
   a_return_stall: assert property (
      exec && (op == 3'd0) && !ASLEEP |=> !HREADYOUT && $stable(PROGRAM_COUNTER) ##1 HREADYOUT)
      else $error("return did not take two cycles");
   a_sleep_enters: assert property (
      exec && (op == 3'd3) && !ASLEEP |=> ASLEEP)
      else $error("sleep did not halt the core");
   a_asleep_idle: assert property (
      exec && ASLEEP |=> HREADYOUT && ASLEEP && $stable(PROGRAM_COUNTER))
      else $error("instruction ran while halted");
   a_power_low: assert property (
      rdone && (addr_q == 8'h08) && slept_q |-> HRDATA[3] == 1'b0)
      else $error("power-down flag not cleared by sleep");
   a_watchdog_zero: assert property (
      rdone && (addr_q == 8'h1c) && ASLEEP |-> HRDATA[15:0] == 16'h0000)
      else $error("watchdog not cleared by sleep");

   c_return: cover property (exec && (op == 3'd0) && !ASLEEP);
   c_sleep: cover property (exec && (op == 3'd3) && !ASLEEP);
   c_status: cover property (rdone && (addr_q == 8'h08) && slept_q);
endmodule

bind core_return_rotate_sleep_sub core_chk #(.PC_WIDTH(PC_WIDTH)) chk
(
   .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ASLEEP(ASLEEP), .PROGRAM_COUNTER(PROGRAM_COUNTER)
);

//--- core_return_rotate_sleep_sub_bench.sv
// Purpose: Self-checking bench for the instruction subset block over AHB-Lite.
// Assumes: One master, single word transfers, HREADY fed back from HREADYOUT.
// Notes:   Expected values are worked out here from the instruction behaviour.
`timescale 1ns/100ps
`include "core_defines.svh"

module core_return_rotate_sleep_sub_bench;
   logic        clk;
   logic        rstn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        asleep;
   logic [12:0] pc;
   int          errors;
   int          samples_checked;
   logic [7:0]  fv;
   logic [7:0]  acc;
   logic [7:0]  res;
   logic        c;
   logic        nc;
   logic [2:0]  rop  [5] = '{3'd1, 3'd1, 3'd2, 3'd2, 3'd2};
   logic        rdst [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0]  sacc [4] = '{8'h05, 8'h06, 8'h0f, 8'h00};
   logic [7:0]  slit [4] = '{8'h05, 8'h05, 8'h10, 8'hff};

   assign hready = hreadyout;

   // Block under test.
   core_return_rotate_sleep_sub uut
   (
      .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .ASLEEP(asleep), .PROGRAM_COUNTER(pc)
   );

   // 200 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Waits for the slave to be ready at a rising edge, with a bound.
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         $display("Error at %0t: ready timeout", $time);
         errors++;
         stop_test();
      end
   endtask

   // One single word transfer: address phase, then data phase.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask

   // Compares a value and counts the outcome.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         errors++;
      end
   endtask

   // Register write.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, {24'h0, a}, d, q);
   endtask

   // Register read compared with an expected word.
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, {24'h0, a}, 32'h0, q);
      check(q, exp);
   endtask

   // Command word: opcode, file address, destination, literal.
   function automatic logic [31:0] cmd(input logic [2:0] op, input logic [6:0] fa,
                                       input logic dst, input logic [7:0] lit);
      return {8'h00, lit, dst, fa, 5'h00, op};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      errors = 0;
      samples_checked = 0;
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd_chk(`ADDR_STATUS, 32'h18);
      rd_chk(8'h40, 32'h0);
      // Rotates through carry at the highest file address.
      fv = 8'he6;
      c = 1'b0;
      acc = 8'h00;
      wr(`ADDR_FILE_PTR, 32'h7f);
      wr(`ADDR_FILE_DATA, {24'h0, fv});
      rd_chk(`ADDR_FILE_PTR, 32'h7f);
      wr(`ADDR_STATUS, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         res = (rop[i] == 3'd1) ? {fv[6:0], c} : {c, fv[7:1]};
         nc = (rop[i] == 3'd1) ? fv[7] : fv[0];
         if (rdst[i])
            fv = res;
         else
            acc = res;
         c = nc;
         wr(`ADDR_CMD, cmd(rop[i], 7'h7f, rdst[i], 8'h00));
         rd_chk(`ADDR_FILE_DATA, {24'h0, fv});
         rd_chk(`ADDR_ACC, {24'h0, acc});
         rd_chk(`ADDR_STATUS, {27'h0, 2'b11, 2'b00, c});
      end
      // Literal minus accumulator, flags meaning no borrow.
      for (int i = 0; i < 4; i++)
      begin
         res = slit[i] - sacc[i];
         wr(`ADDR_ACC, {24'h0, sacc[i]});
         wr(`ADDR_CMD, cmd(3'd4, 7'h00, 1'b0, slit[i]));
         rd_chk(`ADDR_ACC, {24'h0, res});
         rd_chk(`ADDR_STATUS, {27'h0, 2'b11, res == 8'h00, sacc[i][3:0] <= slit[i][3:0],
                sacc[i] <= slit[i]});
      end
      // Illegal opcode is dropped.
      wr(`ADDR_ACC, 32'h3c);
      wr(`ADDR_CMD, cmd(3'd5, 7'h00, 1'b0, 8'hff));
      rd_chk(`ADDR_ACC, 32'h3c);
      // Return pops in order and leaves flags and accumulator alone.
      wr(`ADDR_PC, 32'h0555);
      rd_chk(`ADDR_PC, 32'h0555);
      wr(`ADDR_STATUS, 32'h7);
      wr(`ADDR_STACK, 32'h0123);
      wr(`ADDR_STACK, 32'h1f0e);
      wr(`ADDR_CMD, cmd(3'd0, 7'h00, 1'b0, 8'h00));
      rd_chk(`ADDR_STACK, 32'h1);
      check({19'h0, pc}, 32'h1f0e);
      rd_chk(`ADDR_STATUS, 32'h1f);
      wr(`ADDR_CMD, cmd(3'd0, 7'h00, 1'b0, 8'h00));
      rd_chk(`ADDR_ACC, 32'h3c);
      check({19'h0, pc}, 32'h0123);
      // Sleep: watchdog cleared, flags updated, no instruction runs.
      wr(`ADDR_STATUS, 32'h0);
      repeat (300) @(posedge clk);
      wr(`ADDR_CMD, cmd(3'd3, 7'h00, 1'b0, 8'h00));
      @(posedge clk); // The halt flag lands on the edge that ends the write.
      check({31'h0, asleep}, 32'h1);
      rd_chk(`ADDR_STATUS, 32'h30);
      rd_chk(`ADDR_WATCHDOG, 32'h0);
      wr(`ADDR_STACK, 32'h0aaa);
      wr(`ADDR_CMD, cmd(3'd4, 7'h00, 1'b0, 8'h55));
      wr(`ADDR_CMD, cmd(3'd0, 7'h00, 1'b0, 8'h00));
      rd_chk(`ADDR_ACC, 32'h3c);
      check({19'h0, pc}, 32'h0123);
      rd_chk(`ADDR_STATUS, 32'h30);
      wr(`ADDR_WAKE, 32'h1);
      @(posedge clk); // The wake write clears the flag on the edge that ends it.
      check({31'h0, asleep}, 32'h0);
      wr(`ADDR_CMD, cmd(3'd0, 7'h00, 1'b0, 8'h00));
      rd_chk(`ADDR_STACK, 32'h0);
      check({19'h0, pc}, 32'h0aaa);
      check({31'h0, hresp}, 32'h0);
      stop_test();
   end
endmodule
